/* sar_map.vh */
// sar_map.vh: constants for the converter serial readout block
// assumes: included by the design files by bare name
`ifndef SAR_MAP_VH
`define SAR_MAP_VH

// ----------------------------------------
// result layout
// ----------------------------------------
`define SAR_RES_W 16
`define SAR_RES_MSB 15

// ----------------------------------------
// readout edge counts
// ----------------------------------------
`define SAR_EDGES_BUSY 5'h11
`define SAR_EDGES_PLAIN 5'h10

// ----------------------------------------
// conversion timing
// ----------------------------------------
`define SAR_CLK_PS 4000
`define SAR_TCONV_NS 1000
`define SAR_TCONV_CYC ((`SAR_TCONV_NS * 1000) / `SAR_CLK_PS)

`endif

/* sar_sync.v */
// sar_sync.v: two-flop level synchroniser for one pin input
// assumes: input is asynchronous to clk
`timescale 1ns/10ps
module sar_sync (
   // clock and reset
   input wire clk,
   input wire reset,
   // data
   input wire din,
   output reg dout
);
   reg meta_q;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

/* sar_readout.v */
// sar_readout.v: conversion start and serial result readout of a 16-bit SAR converter
// assumes: pins arrive asynchronously; sclk much slower than core_clk
// Function
// - serial input low at start edge selects daisy-chain, high selects three- or four-wire
// - three-wire: start edge tri-states output, samples, converts regardless of start pin
// - three-wire busy only when start pin low at conversion end
// - busy end: acquire, release output, drive low busy bit, then MSB first
// - busy readout tri-states at 17th falling edge or select release
// - four-wire: start edge with input high selects chip-select, converts regardless
// - input falling edge releases output with MSB, next bits on falling edges
// - plain four-wire tri-states at 16th falling edge or input high
// - data held stable across both clock edges, changes only after falling
// - output driven low when input and start both low, except in conversion and busy or chain readout
// - start edge loads 16-bit shifter; daisy-chain end drives MSB, enters acquisition
// - daisy-chain falling edge shifts input in and presents next bit
// - result is straight binary over sixteen bits
`timescale 1ns/10ps
`include "sar_map.vh"
module sar_readout #(
   parameter CONV_CYC = `SAR_TCONV_CYC
) (
   // clock and reset
   input wire core_clk,
   input wire reset,
   // host pins
   input wire convert_start_pin,
   input wire serial_in,
   input wire serial_clk,
   output reg serial_out,
   output reg serial_out_en,
   // converter core
   input wire [`SAR_RES_MSB:0] sample_code,
   output reg acquiring,
   output reg result_valid
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_CONV = 2'h1;
   localparam ST_WAIT = 2'h2;
   localparam ST_READ = 2'h3;
   // idle: line released, or held low by both-low pins
   // conv: internal timer runs, serial clock ignored, start and input read at its end
   // wait: plain four-wire result waits for its select
   // read: bits leave on serial clock falling edges

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   wire cs_s;
   wire din_s;
   wire sck_s;
   reg cs_q;
   reg din_q;
   reg sck_q;

   sar_sync u_cs (
      .clk(core_clk),
      .reset(reset),
      .din(convert_start_pin),
      .dout(cs_s)
   );
   sar_sync u_din (
      .clk(core_clk),
      .reset(reset),
      .din(serial_in),
      .dout(din_s)
   );
   sar_sync u_sck (
      .clk(core_clk),
      .reset(reset),
      .din(serial_clk),
      .dout(sck_s)
   );

   // ----------------------------------------
   // pin edges
   // ----------------------------------------
   // sync flops read low for two edges after reset while pins idle high:
   // edges and levels wait until the flops hold real pin values
   reg [1:0] warm_q;
   wire live = (warm_q == 2'h3);
   wire cs_rise = live & cs_s & ~cs_q;
   wire din_fall = live & ~din_s & din_q;
   wire sck_fall = live & ~sck_s & sck_q;
   // both select pins low, data line must be driven low
   wire both_low = live & ~cs_s & ~din_s;

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         warm_q <= 2'h0;
         cs_q <= 1'b0;
         din_q <= 1'b0;
         sck_q <= 1'b0;
      end else begin
         if (!live) begin
            warm_q <= warm_q + 2'h1;
         end
         cs_q <= cs_s;
         din_q <= din_s;
         sck_q <= sck_s;
      end
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [1:0] st_q;
   reg [1:0] st_d;
   reg chain_q;
   reg chain_d;
   reg busy_q;
   reg busy_d;
   reg [31:0] cnt_q;
   reg [31:0] cnt_d;
   reg [4:0] edge_q;
   reg [4:0] edge_d;
   reg [`SAR_RES_MSB:0] sh_q;
   reg [`SAR_RES_MSB:0] sh_d;
   reg out_d;
   reg oe_d;
   reg acq_d;
   reg rv_d;
   // select low: start pin in three-wire, serial input in four-wire
   reg three_q;
   reg three_d;

   wire sel_low = three_q ? ~cs_s : ~din_s;
   wire conv_done = (cnt_q == CONV_CYC - 1);
   // readout falling edges until release; the busy bit costs one more
   wire [4:0] edge_next = edge_q + 5'h01;
   wire [4:0] edge_last = busy_q ? `SAR_EDGES_BUSY : `SAR_EDGES_PLAIN;
   wire edge_end = (edge_next == edge_last);

   always @* begin
      st_d = st_q;
      chain_d = chain_q;
      busy_d = busy_q;
      cnt_d = cnt_q;
      edge_d = edge_q;
      sh_d = sh_q;
      out_d = serial_out;
      oe_d = serial_out_en;
      acq_d = acquiring;
      rv_d = 1'b0;
      three_d = three_q;
      if (cs_rise) begin
         // new conversion, whatever state
         st_d = ST_CONV;
         chain_d = ~din_s;
         three_d = 1'b0;
         busy_d = 1'b0;
         cnt_d = 32'h0000_0000;
         oe_d = 1'b0;
         acq_d = 1'b0;
         sh_d = sample_code;
      end else begin
         case (st_q)
            ST_IDLE: begin
               oe_d = 1'b0;
            end
            ST_CONV: begin
               // runs on core clock only, serial clock ignored; start and input levels read at the end
               cnt_d = cnt_q + 32'h0000_0001;
               if (conv_done) begin
                  acq_d = 1'b1;
                  rv_d = 1'b1;
                  edge_d = 5'h00;
                  if (chain_q) begin
                     // chain output stays driven until the next start edge
                     st_d = ST_READ;
                     oe_d = 1'b1;
                     out_d = sh_q[`SAR_RES_MSB];
                  end else if (~cs_s) begin
                     // start low at end: three-wire with busy
                     three_d = 1'b1;
                     busy_d = 1'b1;
                     st_d = ST_READ;
                     oe_d = 1'b1;
                     out_d = 1'b0;
                  end else if (~din_s) begin
                     busy_d = 1'b1;
                     st_d = ST_READ;
                     oe_d = 1'b1;
                     out_d = 1'b0;
                  end else begin
                     st_d = ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               // plain four-wire: result waits for its select to fall
               if (din_fall) begin
                  st_d = ST_READ;
                  oe_d = 1'b1;
                  out_d = sh_q[`SAR_RES_MSB];
               end
            end
            ST_READ: begin
               if (chain_q) begin
                  if (sck_fall) begin
                     sh_d = {sh_q[`SAR_RES_MSB-1:0], din_s};
                     out_d = sh_q[`SAR_RES_MSB-1];
                  end
               end else if (sel_low == 1'b0) begin
                  st_d = ST_IDLE;
                  oe_d = 1'b0;
               end else if (sck_fall) begin
                  edge_d = edge_next;
                  if (edge_end) begin
                     st_d = ST_IDLE;
                     oe_d = 1'b0;
                  end else if (busy_q && edge_q == 5'h00) begin
                     out_d = sh_q[`SAR_RES_MSB];
                  end else begin
                     sh_d = {sh_q[`SAR_RES_MSB-1:0], 1'b0};
                     out_d = sh_q[`SAR_RES_MSB-1];
                  end
               end
            end
            default: begin
               st_d = ST_IDLE;
            end
         endcase
      end
      // both select pins low with no conversion running;
      // busy and chain readouts keep their own bits on the line
      if (both_low && st_d != ST_CONV && !(st_d == ST_READ && busy_d)) begin
         if (!(chain_d && st_d == ST_READ)) begin
            oe_d = 1'b1;
            out_d = 1'b0;
         end
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_q <= ST_IDLE;
         chain_q <= 1'b0;
         busy_q <= 1'b0;
         three_q <= 1'b0;
         edge_q <= 5'h00;
      end else begin
         st_q <= st_d;
         chain_q <= chain_d;
         busy_q <= busy_d;
         three_q <= three_d;
         edge_q <= edge_d;
      end
   end

   // ----------------------------------------
   // conversion timer
   // ----------------------------------------
   // counts core clocks only, the serial clock plays no part
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 32'h0000_0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------
   // result shifter
   // ----------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sh_q <= 16'h0000;
      end else begin
         sh_q <= sh_d;
      end
   end

   // ----------------------------------------
   // pin and core outputs, all registered
   // ----------------------------------------
   // acquiring idles high: the core stays in acquisition until a start edge
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         serial_out <= 1'b0;
         serial_out_en <= 1'b0;
         acquiring <= 1'b1;
         result_valid <= 1'b0;
      end else begin
         serial_out <= out_d;
         serial_out_en <= oe_d;
         acquiring <= acq_d;
         result_valid <= rv_d;
      end
   end

endmodule

/* sar_host.sv */
// sar_host.sv: host model that drives the converter pins
// assumes: paced by core_clk; pull-up on the data line
`timescale 1ns/10ps
module sar_host (
   // clock
   input wire core_clk,
   // pins
   output reg convert_start_pin,
   output reg serial_in,
   output reg serial_clk,
   input wire serial_out,
   input wire serial_out_en
);
   initial {convert_start_pin, serial_in, serial_clk} = 3'b110;
   // ----
   // pin tasks
   // ----
   task tick(input integer n);
      begin
         repeat (n) @(posedge core_clk);
         #1;
      end
   endtask
   // serial_in set first, start then held high until the next start
   task start(input reg din);
      begin
         serial_in = din;
         convert_start_pin = 1'b0;
         tick(4);
         convert_start_pin = 1'b1;
         tick(1);
      end
   endtask
   // 160 ns clock periods, level taken at each fall
   task read(input integer n, input [31:0] feed, output [31:0] v);
      integer i;
      begin
         v = 32'h0;
         for (i = 0; i < n; i = i + 1) begin
            serial_in = feed[31 - i];
            serial_clk = ~serial_clk;
            tick(20);
            v = {v[30:0], serial_out_en ? serial_out : 1'b1};
            serial_clk = ~serial_clk;
            tick(20);
         end
      end
   endtask
endmodule

/* sar_readout_checker.sv */
// sar_readout_checker.sv: pin timing checks for the readout block
// assumes: bound into sar_readout; pins steady around start edges
`timescale 1ns/10ps
module sar_readout_checker #(
   parameter int CONV_CYC = 250
) (
   // clock and reset
   input wire core_clk,
   input wire reset,
   // pins and core
   input wire convert_start_pin,
   input wire serial_in,
   input wire serial_clk,
   input wire serial_out,
   input wire serial_out_en,
   input wire [15:0] sample_code,
   input wire acquiring,
   input wire result_valid
);
   reg chain_q;
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         chain_q <= 1'b0;
      end else if ($fell(acquiring)) begin
         chain_q <= !$past(serial_in, 2);
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence s_sel_drop;
      ($rose(serial_in) || $rose(convert_start_pin)) && acquiring && !chain_q;
   endsequence
   a_conv_len: assert property (
      $fell(acquiring) |-> ##CONV_CYC (result_valid && acquiring)) else $error("conv length");
   a_hiz_conv: assert property (
      !acquiring |-> !serial_out_en) else $error("driven in conversion");
   a_both_low: assert property (
      (!convert_start_pin && !serial_in) [*5] |=> serial_out_en && !serial_out)
      else $error("both low not driven low");
   a_busy_bit: assert property (
      result_valid && !chain_q && !(serial_in && convert_start_pin)
      |=> serial_out_en && !serial_out) else $error("no busy bit");
   a_plain_quiet: assert property (
      result_valid && !chain_q && serial_in && convert_start_pin |=> !serial_out_en)
      else $error("unexpected busy bit");
   a_chain_msb: assert property (
      result_valid && chain_q |=> serial_out_en && serial_out == sample_code[15])
      else $error("chain msb wrong");
   a_sel_release: assert property (
      s_sel_drop |-> ##[1:6] !serial_out_en) else $error("select release ignored");
   a_data_stable: assert property (
      serial_clk [*6] |-> $stable(serial_out)) else $error("data moved with clock high");
endmodule
bind sar_readout sar_readout_checker #(.CONV_CYC(CONV_CYC)) chk (.core_clk(core_clk),
   .reset(reset), .convert_start_pin(convert_start_pin), .serial_in(serial_in),
   .serial_clk(serial_clk), .serial_out(serial_out), .serial_out_en(serial_out_en),
   .sample_code(sample_code), .acquiring(acquiring), .result_valid(result_valid));

/* sar_readout_bench.sv */
// sar_readout_bench.sv: scenario bench for the readout block
// assumes: sar_host on the pins; conversion count cut to 20
`timescale 1ns/10ps
module sar_readout_bench;
   reg core_clk, reset;
   reg [15:0] code;
   reg [31:0] v;
   wire st, si, sc, so, oe, acq, rv;
   integer err_total, checked, k;
   sar_readout #(.CONV_CYC(20)) uut (.core_clk(core_clk), .reset(reset),
      .convert_start_pin(st), .serial_in(si), .serial_clk(sc), .serial_out(so),
      .serial_out_en(oe), .sample_code(code), .acquiring(acq), .result_valid(rv));
   sar_host h (.core_clk(core_clk), .convert_start_pin(st), .serial_in(si),
      .serial_clk(sc), .serial_out(so), .serial_out_en(oe));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task tally_and_finish;
      begin
         $display("checked=%0d err_total=%0d", checked, err_total);
         if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] want);
      begin
         checked = checked + 1;
         if (seen !== want) begin
            err_total = err_total + 1;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
         end
      end
   endtask
   task wait_done;
      begin
         k = 0;
         while (rv !== 1'b1 && k < 100) begin
            h.tick(1);
            k = k + 1;
         end
         if (k == 100) begin
            err_total = err_total + 1;
            tally_and_finish;
         end
         h.tick(2);
      end
   endtask
   // ----
   // scenarios
   // ----
   task s_plain4;
      begin
         code = 16'hA5C3;
         h.start(1'b1);
         wait_done;
         check(oe, 1'b0);
         h.serial_in = 1'b0;
         h.tick(6);
         check({oe, so}, {1'b1, code[15]});
         h.read(16, 32'h0, v);
         check(v[15:0], code);
         check(oe, 1'b0);
         h.serial_in = 1'b1;
      end
   endtask
   task s_cut4;
      begin
         code = {code[3:0], code[15:4]};
         h.start(1'b1);
         wait_done;
         h.serial_in = 1'b0;
         h.tick(6);
         h.read(4, 32'h0, v);
         check(v[3:0], code[15:12]);
         check(oe, 1'b1);
         h.serial_in = 1'b1;
         h.tick(6);
         check(oe, 1'b0);
      end
   endtask
   task s_busy4;
      begin
         code = ~{code[7:0], code[15:8]};
         h.start(1'b1);
         h.tick(6);
         h.serial_in = 1'b0;
         wait_done;
         check({oe, so}, 2'b10);
         h.read(17, 32'h0, v);
         check(v[16:0], {1'b0, code});
         check(oe, 1'b0);
         h.serial_in = 1'b1;
      end
   endtask
   task s_busy3;
      begin
         code = {code[0], code[15:1]};
         h.start(1'b1);
         h.tick(6);
         h.convert_start_pin = 1'b0;
         wait_done;
         check({oe, so}, 2'b10);
         h.read(8, 32'hFFFFFFFF, v);
         check(v[7:0], {1'b0, code[15:9]});
         h.convert_start_pin = 1'b1;
         h.tick(6);
         check(oe, 1'b0);
         wait_done;
      end
   endtask
   task s_chain;
      begin
         code = ~code;
         h.serial_in = 1'b0;
         h.convert_start_pin = 1'b0;
         h.tick(8);
         check({oe, so}, 2'b10);
         h.start(1'b0);
         wait_done;
         check({oe, so}, {1'b1, code[15]});
         h.read(32, 32'hF00D0000, v);
         check(v, {code, 16'hF00D});
      end
   endtask
   initial begin
      err_total = 0;
      checked = 0;
      code = 16'h0000;
      reset = 1'b1;
      repeat (20) @(posedge core_clk);
      #1 reset = 1'b0;
      h.tick(2);
      h.tick(6);
      check({oe, acq, rv}, 3'b010);
      s_plain4;
      s_cut4;
      s_busy4;
      s_busy3;
      s_chain;
      tally_and_finish;
   end
endmodule
